// ### hdl/grdp_pkg.sv
// Shared constants, types and decoders for the raster draw processor bus engine.
// Assumes one clock domain (mclk) and an outside bus sequencer that answers with wait.

package grdp_pkg;

   // ----------------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int SYNC_W = 18;

   // ----------------------------------------------------------------------
   // Bus status line codes
   // ----------------------------------------------------------------------
   localparam logic [1:0] BS_IDLE = 2'h0;
   localparam logic [1:0] BS_OPERAND = 2'h1;
   localparam logic [1:0] BS_DRAW = 2'h2;
   localparam logic [1:0] BS_SCREEN = 2'h3;

   // ----------------------------------------------------------------------
   // Timing counts and reset values
   // ----------------------------------------------------------------------
   localparam logic [15:0] REFRESH_PERIOD = 16'h0040;
   localparam logic [2:0] LB_SETTLE_CYCLES = 3'h4;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 18'h20000;
   localparam logic [ADDR_W-1:0] REFRESH_ADDR_RESET = 24'h000000;

   // ----------------------------------------------------------------------
   // Cycle classes and sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      CYC_READ = 3'h0,
      CYC_WRITE = 3'h1,
      CYC_SCREEN = 3'h2,
      CYC_SRC_READ = 3'h3,
      CYC_DST_WRITE = 3'h4,
      CYC_BLT_RMW = 3'h5,
      CYC_LINE_RMW = 3'h6
   } grdp_cycle_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_T1 = 3'h1,
      ST_T2 = 3'h2,
      ST_T3 = 3'h3,
      ST_HOLD = 3'h4,
      ST_SETTLE = 3'h5
   } grdp_state_type;

   function automatic logic isDrawing(input grdp_cycle_type kind);
      isDrawing = (kind == CYC_SRC_READ) || (kind == CYC_DST_WRITE) ||
                  (kind == CYC_BLT_RMW) || (kind == CYC_LINE_RMW);
   endfunction : isDrawing

   function automatic logic writesData(input grdp_cycle_type kind);
      writesData = (kind == CYC_WRITE) || (kind == CYC_DST_WRITE);
   endfunction : writesData

   // Returns {bus status, read_n, write_n}
   function automatic logic [3:0] cycleStatus(input grdp_cycle_type kind);
      unique case (kind)
         CYC_READ: cycleStatus = {BS_OPERAND, 1'h0, 1'h1};
         CYC_WRITE: cycleStatus = {BS_OPERAND, 1'h1, 1'h0};
         CYC_SCREEN: cycleStatus = {BS_SCREEN, 1'h0, 1'h1};
         CYC_SRC_READ: cycleStatus = {BS_DRAW, 1'h0, 1'h1};
         CYC_DST_WRITE: cycleStatus = {BS_DRAW, 1'h1, 1'h0};
         default: cycleStatus = {BS_DRAW, 1'h0, 1'h0};
      endcase
   endfunction : cycleStatus

endpackage : grdp_pkg

// ### hdl/grdp_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
// Assumes each bit is a slow level; no multi-bit coherence is promised.

`timescale 1ns/100ps

module grdp_sync (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [grdp_pkg::SYNC_W-1:0] pinIn,
   output logic [grdp_pkg::SYNC_W-1:0] syncOut
);
   import grdp_pkg::*;

   logic [SYNC_W-1:0] stage1;

   genvar i;
   generate
      for (i = 0; i < SYNC_W; i++) begin : g_bit
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               stage1[i] <= SYNC_RESET[i];
               syncOut[i] <= SYNC_RESET[i];
            end else begin
               stage1[i] <= pinIn[i];
               syncOut[i] <= stage1[i];
            end
         end
      end
   endgenerate

endmodule : grdp_sync

// ### hdl/grdp_bus_engine.sv
// Bus cycle engine of the raster draw processor: issues classed cycles, honours wait,
// yields the bus on hold and drives the pixel datapath unit's own inputs.
// Assumes an outside sequencer decodes the status and answers with an active-low wait.
//
// Functional notes
// - Release bus before acknowledging hold request.
// - Status and read/write lines classify cycles.
// - Non-drawing cycles last three clocks minimum.
// - Drawing cycles last two clocks minimum.
// - Processor drives six pixel-unit inputs itself.
// - Line/block mode changes well before drawing.
// - Strobe, address, status in first state.
// - Low wait in second state repeats it.
// - Refresh request pulses at constant intervals.

`timescale 1ns/100ps

module grdp_bus_engine (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic reqValid,
   input wire grdp_pkg::grdp_cycle_type reqKind,
   input wire logic [grdp_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [grdp_pkg::DATA_W-1:0] reqData,
   input wire logic [3:0] reqPixAddr,
   input wire logic reqLeftMask,
   input wire logic reqRightMask,
   input wire logic reqFifoRead,
   input wire logic reqSrcEnable,
   output logic reqReady,
   output logic rspValid,
   output logic [grdp_pkg::DATA_W-1:0] rspData,
   input wire logic waitN,
   input wire logic holdReq,
   input wire logic [grdp_pkg::DATA_W-1:0] adIn,
   output logic [grdp_pkg::DATA_W-1:0] adOut,
   output logic adOe,
   output logic ale,
   output logic [1:0] busStatusLines,
   output logic readN,
   output logic writeN,
   output logic [7:0] addrHigh,
   output logic busOe,
   output logic busReleaseAck,
   output logic displayRefreshRequest,
   output logic pixAddr0LeftMaskEn,
   output logic pixAddr1RightMaskEn,
   output logic pixAddr2FifoWrite,
   output logic pixAddr3FifoRead,
   output logic lineBlockMode,
   output logic blitSourceEnable
);
   import grdp_pkg::*;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [SYNC_W-1:0] syncBus;
   logic waitSync;
   logic holdSync;
   logic [DATA_W-1:0] adSync;

   grdp_sync u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .pinIn({waitN, holdReq, adIn}),
      .syncOut(syncBus)
   );

   assign waitSync = syncBus[17];
   assign holdSync = syncBus[16];
   assign adSync = syncBus[15:0];

   // ----------------------------------------------------------------------
   // Cycle control
   // ----------------------------------------------------------------------
   grdp_state_type state, next_state;
   grdp_cycle_type kind, next_kind;
   logic [ADDR_W-1:0] addr, next_addr, refreshAddr, next_refreshAddr;
   logic [DATA_W-1:0] data, next_data, next_rspData;
   logic [3:0] pixAddr, next_pixAddr;
   logic leftMask, next_leftMask, rightMask, next_rightMask;
   logic fifoRead, next_fifoRead, srcEnable, next_srcEnable;
   logic lineMode, next_lineMode, lineNeed;
   logic [2:0] settle, next_settle;
   logic [15:0] refreshTimer, next_refreshTimer;
   logic refreshPending, next_refreshPending, refreshTick, issueRefresh;
   logic next_rspValid;

   assign refreshTick = (refreshTimer == REFRESH_PERIOD - 16'h0001);
   assign lineNeed = (reqKind == CYC_LINE_RMW);

   always_comb begin
      next_state = state;
      next_kind = kind;
      next_addr = addr;
      next_data = data;
      next_pixAddr = pixAddr;
      next_leftMask = leftMask;
      next_rightMask = rightMask;
      next_fifoRead = fifoRead;
      next_srcEnable = srcEnable;
      next_lineMode = lineMode;
      next_settle = settle;
      next_refreshAddr = refreshAddr;
      next_rspData = rspData;
      next_rspValid = 1'h0;
      issueRefresh = 1'h0;
      // Constant interval, independent of bus traffic
      next_refreshTimer = refreshTick ? 16'h0000 : refreshTimer + 16'h0001;
      unique case (state)
         ST_IDLE: begin
            if (reqValid && reqReady) begin
               next_kind = reqKind;
               next_addr = reqAddr;
               next_data = reqData;
               next_pixAddr = reqPixAddr;
               next_leftMask = reqLeftMask;
               next_rightMask = reqRightMask;
               next_fifoRead = reqFifoRead;
               if (isDrawing(reqKind)) begin
                  next_srcEnable = reqSrcEnable;
               end
               // Mode flips ahead of the drawing cycle, never under it
               if (isDrawing(reqKind) && (lineNeed != lineMode)) begin
                  next_lineMode = lineNeed;
                  next_settle = LB_SETTLE_CYCLES - 3'h1;
                  next_state = ST_SETTLE;
               end else begin
                  next_state = ST_T1;
               end
            end else if (refreshPending) begin
               next_kind = CYC_SCREEN;
               next_addr = refreshAddr;
               next_refreshAddr = refreshAddr + 24'h000001;
               issueRefresh = 1'h1;
               next_state = ST_T1;
            end else if (holdSync) begin
               next_state = ST_HOLD;
            end
         end
         ST_SETTLE: begin
            if (settle == 3'h0) begin
               next_state = ST_T1;
            end else begin
               next_settle = settle - 3'h1;
            end
         end
         ST_T1: begin
            next_state = ST_T2;
         end
         ST_T2: begin
            // Low wait keeps T2; drawing cycles end here, others take T3
            if (waitSync) begin
               next_state = isDrawing(kind) ? ST_IDLE : ST_T3;
            end
         end
         ST_T3: begin
            if (kind == CYC_READ) begin
               next_rspData = adSync;
               next_rspValid = 1'h1;
            end
            next_state = ST_IDLE;
         end
         ST_HOLD: begin
            if (!holdSync) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // A tick in the issuing cycle stays pending
      next_refreshPending = refreshTick | (refreshPending & ~issueRefresh);
   end

   // ----------------------------------------------------------------------
   // Pin outputs, all computed from the next cycle state
   // ----------------------------------------------------------------------
   logic owning, drawing, firstT2;
   logic next_ale, next_busOe, next_adOe, next_readN, next_writeN, next_reqReady;
   logic next_ack, next_pix0, next_pix1, next_pix2, next_pix3;
   logic [1:0] next_bs;
   logic [DATA_W-1:0] next_adOut;

   always_comb begin
      owning = (next_state == ST_T1) || (next_state == ST_T2) || (next_state == ST_T3);
      drawing = owning && isDrawing(next_kind);
      firstT2 = (next_state == ST_T2) && (state == ST_T1);
      next_ale = (next_state == ST_T1);
      if (owning) begin
         {next_bs, next_readN, next_writeN} = cycleStatus(next_kind);
      end else begin
         {next_bs, next_readN, next_writeN} = {BS_IDLE, 1'h1, 1'h1};
      end
      // Floating everything before acknowledging keeps the host off a driven bus
      next_busOe = (next_state != ST_HOLD);
      next_ack = (next_state == ST_HOLD) && (state == ST_HOLD);
      next_adOe = next_ale || (owning && writesData(next_kind));
      next_adOut = next_ale ? next_addr[DATA_W-1:0] : next_data;
      // Line mode carries pixel address; block mode carries masks and fifo strobes
      if (drawing && next_lineMode) begin
         {next_pix3, next_pix2, next_pix1, next_pix0} = next_pixAddr;
      end else if (drawing) begin
         next_pix0 = next_leftMask;
         next_pix1 = next_rightMask;
         next_pix2 = firstT2 && (next_kind == CYC_SRC_READ);
         next_pix3 = firstT2 && next_fifoRead && (next_kind != CYC_SRC_READ);
      end else begin
         {next_pix3, next_pix2, next_pix1, next_pix0} = 4'h0;
      end
      next_reqReady = (next_state == ST_IDLE) && !next_refreshPending && !holdSync;
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         kind <= CYC_READ;
         addr <= '0;
         data <= '0;
         pixAddr <= 4'h0;
         leftMask <= 1'h0;
         rightMask <= 1'h0;
         fifoRead <= 1'h0;
         srcEnable <= 1'h0;
         lineMode <= 1'h0;
         settle <= 3'h0;
         refreshTimer <= 16'h0000;
         refreshPending <= 1'h0;
         refreshAddr <= REFRESH_ADDR_RESET;
         rspData <= '0;
         rspValid <= 1'h0;
         reqReady <= 1'h0;
         ale <= 1'h0;
         busStatusLines <= BS_IDLE;
         readN <= 1'h1;
         writeN <= 1'h1;
         addrHigh <= 8'h00;
         busOe <= 1'h1;
         adOe <= 1'h0;
         adOut <= '0;
         busReleaseAck <= 1'h0;
         displayRefreshRequest <= 1'h0;
         pixAddr0LeftMaskEn <= 1'h0;
         pixAddr1RightMaskEn <= 1'h0;
         pixAddr2FifoWrite <= 1'h0;
         pixAddr3FifoRead <= 1'h0;
         lineBlockMode <= 1'h0;
         blitSourceEnable <= 1'h0;
      end else begin
         state <= next_state;
         kind <= next_kind;
         addr <= next_addr;
         data <= next_data;
         pixAddr <= next_pixAddr;
         leftMask <= next_leftMask;
         rightMask <= next_rightMask;
         fifoRead <= next_fifoRead;
         srcEnable <= next_srcEnable;
         lineMode <= next_lineMode;
         settle <= next_settle;
         refreshTimer <= next_refreshTimer;
         refreshPending <= next_refreshPending;
         refreshAddr <= next_refreshAddr;
         rspData <= next_rspData;
         rspValid <= next_rspValid;
         reqReady <= next_reqReady;
         ale <= next_ale;
         busStatusLines <= next_bs;
         readN <= next_readN;
         writeN <= next_writeN;
         addrHigh <= next_addr[ADDR_W-1:DATA_W];
         busOe <= next_busOe;
         adOe <= next_adOe;
         adOut <= next_adOut;
         busReleaseAck <= next_ack;
         displayRefreshRequest <= refreshTick;
         pixAddr0LeftMaskEn <= next_pix0;
         pixAddr1RightMaskEn <= next_pix1;
         pixAddr2FifoWrite <= next_pix2;
         pixAddr3FifoRead <= next_pix3;
         lineBlockMode <= next_lineMode;
         blitSourceEnable <= next_srcEnable;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_hold_float: assert property (@(posedge mclk) disable iff (!reset_n)
      busReleaseAck |-> !busOe && !adOe && !ale)
      else $error("hold acknowledged while bus still driven");

   a_status_class: assert property (@(posedge mclk) disable iff (!reset_n)
      (ale && busStatusLines == BS_SCREEN) |-> (!readN && writeN))
      else $error("screen refresh cycle with wrong read/write status");

   a_nondraw_length: assert property (@(posedge mclk) disable iff (!reset_n)
      (ale && busStatusLines == BS_OPERAND) |=> (busStatusLines == BS_OPERAND)[*2])
      else $error("non-drawing cycle shorter than three clocks");

   a_draw_length: assert property (@(posedge mclk) disable iff (!reset_n)
      (ale && busStatusLines == BS_DRAW) |=> (busStatusLines == BS_DRAW && !ale))
      else $error("drawing cycle shorter than two clocks");

   a_fifo_write: assert property (@(posedge mclk) disable iff (!reset_n)
      (ale && busStatusLines == BS_DRAW && !lineBlockMode && !readN && writeN)
         |=> pixAddr2FifoWrite ##1 !pixAddr2FifoWrite)
      else $error("fifo write not strobed in first T2 of source read");

   a_mode_static: assert property (@(posedge mclk) disable iff (!reset_n)
      $changed(lineBlockMode) |-> (!ale)[*4])
      else $error("line/block mode changed too close to a cycle start");

   a_ale_first: assert property (@(posedge mclk) disable iff (!reset_n)
      ale |-> busOe && adOe && busStatusLines != BS_IDLE && adOut == addr[DATA_W-1:0])
      else $error("address strobe without address and status");

   a_wait_repeat: assert property (@(posedge mclk) disable iff (!reset_n)
      (state == ST_T2 && !waitSync) |=> (state == ST_T2) && $stable(busStatusLines))
      else $error("second state not repeated on low wait");

   a_refresh_spacing: assert property (@(posedge mclk) disable iff (!reset_n)
      displayRefreshRequest |=> (!displayRefreshRequest)[*8])
      else $error("display refresh requests too close together");

endmodule : grdp_bus_engine

// ### verif/grdp_seq_model.sv
// Outside bus sequencer model: answers the engine with wait, read data and hold.
// Assumes the engine pins as ports and a bench that sets wait count and hold.

`timescale 1ns/100ps

module grdp_seq_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ale,
   input wire logic [1:0] busStatusLines,
   input wire logic readN,
   input wire logic writeN,
   input wire logic displayRefreshRequest,
   input wire logic [15:0] adOut,
   input wire logic [3:0] waitCycles,
   input wire logic holdCmd,
   output logic waitN,
   output logic holdReq,
   output logic [15:0] adIn
);
   logic [3:0] cnt;
   logic [3:0] wLat;
   logic busy, drawCyc, setupCyc, refreshDue;
   logic [15:0] rdVal;
   // Bits: data latch, pixel latch, data out enable, pixel out enable
   logic [3:0] drawStrobes;
   // Bits: control register load, function select load
   logic [1:0] setupStrobes;

   // --------------------------------------------------------------
   // Cycle tracking
   // --------------------------------------------------------------
   // Wait rests low: the engine's two-flop lag makes a late wait useless,
   // so the model releases the engine instead of stopping it.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         wLat <= 4'h0;
         waitN <= 1'b0;
         rdVal <= 16'h0000;
         holdReq <= 1'b0;
         drawCyc <= 1'b0;
         setupCyc <= 1'b0;
         refreshDue <= 1'b0;
      end else begin
         // A due screen refresh outranks a new hold; a granted hold is kept
         holdReq <= holdCmd && (holdReq || !refreshDue);
         // A refresh request stays due until the screen cycle's address strobe
         if (displayRefreshRequest) begin
            refreshDue <= 1'b1;
         end else if (ale && busStatusLines == 2'h3) begin
            refreshDue <= 1'b0;
         end
         if (ale) begin
            busy <= 1'b1;
            drawCyc <= (busStatusLines == 2'h2);
            setupCyc <= (busStatusLines == 2'h1) && !writeN;
            cnt <= 4'h0;
            wLat <= waitCycles;
            rdVal <= adOut ^ 16'h5A3C;
         end else if (busy) begin
            cnt <= cnt + 4'h1;
            waitN <= (cnt >= wLat) && (cnt < wLat + 4'h2);
            busy <= (cnt < wLat + 4'h3);
         end
      end
   end

   // Released bus shows the inverse so a stale value never passes
   assign adIn = busy ? rdVal : ~rdVal;

   // Pixel unit strobes only while the data phase of a matching cycle is open
   assign drawStrobes = {4{busy && drawCyc && waitN}} & {!readN, !readN, !writeN, !writeN};
   assign setupStrobes = {2{busy && setupCyc && waitN}};
endmodule : grdp_seq_model

// ### verif/grdp_bus_engine_tb_top.sv
// Self-checking bench of the bus engine against the sequencer model.
// Assumes the package constants and the engine's hand-over timing.

`timescale 1ns/100ps

module grdp_bus_engine_tb_top;
   import grdp_pkg::*;
   typedef struct packed {
      grdp_cycle_type kind;
      logic [23:0] addr;
      logic [15:0] data;
      logic [3:0] pix;
      logic lm, rm, fr, se;
   } grdp_note_type;
   logic mclk, reset_n, reqValid, reqLeftMask, reqRightMask, reqFifoRead, reqSrcEnable;
   logic reqReady, rspValid, waitN, holdReq, adOe, ale, readN, writeN, busOe, holdCmd;
   logic busReleaseAck, displayRefreshRequest, lineBlockMode, blitSourceEnable, lbPrev;
   grdp_cycle_type reqKind;
   logic [23:0] reqAddr;
   logic [15:0] reqData, adIn, adOut, rspData;
   logic [3:0] reqPixAddr, waitCycles, pixLines, expPix;
   logic [1:0] busStatusLines;
   logic [7:0] addrHigh;
   grdp_note_type notes[$];
   grdp_note_type cur;
   logic [15:0] rdq[$];
   logic measuring, inT2;
   int error_cnt, comparisons, cycles, durCnt, minLen, lbStable, refAddr, seed;
   int drrqGap = -1000;

   grdp_bus_engine grdp_bus_engine_i (.mclk(mclk), .reset_n(reset_n), .reqValid(reqValid),
      .reqKind(reqKind), .reqAddr(reqAddr), .reqData(reqData), .reqPixAddr(reqPixAddr),
      .reqLeftMask(reqLeftMask), .reqRightMask(reqRightMask), .reqFifoRead(reqFifoRead),
      .reqSrcEnable(reqSrcEnable), .reqReady(reqReady), .rspValid(rspValid),
      .rspData(rspData), .waitN(waitN), .holdReq(holdReq), .adIn(adIn), .adOut(adOut),
      .adOe(adOe), .ale(ale), .busStatusLines(busStatusLines), .readN(readN),
      .writeN(writeN), .addrHigh(addrHigh), .busOe(busOe), .busReleaseAck(busReleaseAck),
      .displayRefreshRequest(displayRefreshRequest), .pixAddr0LeftMaskEn(pixLines[0]),
      .pixAddr1RightMaskEn(pixLines[1]), .pixAddr2FifoWrite(pixLines[2]),
      .pixAddr3FifoRead(pixLines[3]), .lineBlockMode(lineBlockMode),
      .blitSourceEnable(blitSourceEnable));

   grdp_seq_model grdp_seq_model_i (.mclk(mclk), .reset_n(reset_n), .ale(ale),
      .busStatusLines(busStatusLines), .readN(readN), .writeN(writeN),
      .displayRefreshRequest(displayRefreshRequest),
      .adOut(adOut), .waitCycles(waitCycles), .holdCmd(holdCmd), .waitN(waitN),
      .holdReq(holdReq), .adIn(adIn));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // {status, read_n, write_n} per kind
   function automatic logic [3:0] expStatus(input grdp_cycle_type k);
      case (k)
         CYC_READ: return 4'h5;
         CYC_WRITE: return 4'h6;
         CYC_SCREEN: return 4'hD;
         CYC_SRC_READ: return 4'h9;
         CYC_DST_WRITE: return 4'hA;
         default: return 4'h8;
      endcase
   endfunction : expStatus

   // Bit 23 set keeps requests apart from refresh addresses counting from 0
   function automatic grdp_note_type mk(input grdp_cycle_type k);
      grdp_note_type n;
      n = grdp_note_type'({$urandom, $urandom});
      n.kind = k;
      n.addr[23] = 1'b1;
      if (k != CYC_DST_WRITE && k != CYC_BLT_RMW) n.fr = 1'b0;
      return n;
   endfunction : mk

   task automatic issue(input grdp_note_type n);
      int t;
      @(posedge mclk);
      #1;
      reqKind = n.kind;
      {reqValid, reqAddr, reqData, reqPixAddr} = {1'b1, n.addr, n.data, n.pix};
      {reqLeftMask, reqRightMask, reqFifoRead, reqSrcEnable} = {n.lm, n.rm, n.fr, n.se};
      waitCycles = 4'($urandom_range(3, 0));
      notes.push_back(n);
      if (n.kind == CYC_READ) rdq.push_back(n.addr[15:0] ^ 16'h5A3C);
      t = 0;
      do begin
         @(negedge mclk);
         t++;
      end while (reqReady !== 1'b1 && t < 500);
      @(posedge mclk);
      #1;
      reqValid = 1'b0;
   endtask : issue

   // --------------------------------------------------------------
   // Output watcher
   // --------------------------------------------------------------
   always @(negedge mclk) begin
      if (reset_n) begin
         cycles++;
         if (cycles > 20000) begin
            error_cnt++;
            tally_and_finish();
         end
         if (busReleaseAck) check("float", {ale, busOe, adOe}, 3'h0);
         if (busStatusLines != BS_DRAW)
            check("draw strobes idle", grdp_seq_model_i.drawStrobes, 4'h0);
         if (busStatusLines != BS_OPERAND)
            check("setup strobes idle", grdp_seq_model_i.setupStrobes, 2'h0);
         lbStable = (lineBlockMode === lbPrev) ? lbStable + 1 : 0;
         lbPrev = lineBlockMode;
         drrqGap++;
         if (displayRefreshRequest) begin
            if (drrqGap > 0) check("refresh gap", drrqGap, REFRESH_PERIOD);
            drrqGap = 0;
         end
         if (rspValid) begin
            if (rdq.size() == 0) check("spurious read", 1'b1, 1'b0);
            else check("read data", rspData, rdq.pop_front());
         end
         if (inT2) begin
            inT2 = 1'b0;
            if (cur.kind == CYC_LINE_RMW) expPix = cur.pix;
            else if (cur.kind > CYC_SCREEN)
               expPix = {cur.fr, cur.kind == CYC_SRC_READ, cur.rm, cur.lm};
            else expPix = 4'h0;
            check("pixel lines", pixLines, expPix);
            if (cur.kind > CYC_SCREEN) check("source enable", blitSourceEnable, cur.se);
            if (cur.kind == CYC_WRITE || cur.kind == CYC_DST_WRITE)
               check("write data", {adOe, adOut}, {1'b1, cur.data});
         end
         if (measuring) begin
            durCnt++;
            if (reqReady) begin
               check("cycle length", durCnt >= minLen, 1'b1);
               measuring = 1'b0;
            end
         end
         if (ale) begin
            measuring = 1'b1;
            durCnt = 0;
            minLen = 3;
            if (busStatusLines == 2'h3 && addrHigh == 8'h00) begin
               check("refresh", {busStatusLines, readN, writeN, adOut}, {4'hD, refAddr[15:0]});
               refAddr++;
            end else if (notes.size() == 0) check("stray ale", 1'b1, 1'b0);
            else begin
               cur = notes.pop_front();
               if (cur.kind > CYC_SCREEN) minLen = 2;
               check("status", {busStatusLines, readN, writeN}, expStatus(cur.kind));
               check("address", {adOe, addrHigh, adOut}, {1'b1, cur.addr});
               if (cur.kind > CYC_SCREEN)
                  check("mode", {lineBlockMode, lbStable >= 3}, {cur.kind == CYC_LINE_RMW, 1'b1});
               inT2 = 1'b1;
            end
         end
      end
   end

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      int t;
      {reset_n, reqValid, reqLeftMask, reqRightMask, reqFifoRead, reqSrcEnable} = 6'h00;
      reqKind = CYC_READ;
      {reqAddr, reqData, reqPixAddr, waitCycles, holdCmd} = '0;
      {measuring, inT2, lbPrev} = 3'h0;
      seed = $urandom(28);
      repeat (6) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      repeat (4) @(posedge mclk);
      for (int k = 0; k < 7; k++) issue(mk(grdp_cycle_type'(k)));
      $display("test every cycle kind done");
      repeat (30) issue(mk(grdp_cycle_type'($urandom_range(6, 0))));
      $display("test random back-to-back cycles done");
      @(posedge mclk);
      #1;
      holdCmd = 1'b1;
      t = 0;
      while (busReleaseAck !== 1'b1 && t < 60) begin
         @(negedge mclk);
         t++;
      end
      check("hold ack", {busReleaseAck, busOe, adOe}, 3'h4);
      fork
         issue(mk(CYC_READ));
         begin
            repeat (8) @(negedge mclk);
            check("refused in hold", {reqReady, ale}, 2'h0);
            @(posedge mclk);
            #1;
            holdCmd = 1'b0;
         end
      join
      $display("test hold done");
      repeat (150) @(negedge mclk);
      check("all cycles seen", notes.size() + rdq.size(), 0);
      tally_and_finish();
   end
endmodule : grdp_bus_engine_tb_top
